// *** rtl/gpio_exp_pkg.sv ***
// Shared constants and types for the sixteen-line serial GPIO expander
package gpio_exp_pkg;

  // ************************************************************
  // Register pointer values (low three bits of the command byte)
  // ************************************************************
  localparam logic [2:0] REG_IN0 = 3'h0;
  localparam logic [2:0] REG_IN1 = 3'h1;
  localparam logic [2:0] REG_OUT0 = 3'h2;
  localparam logic [2:0] REG_OUT1 = 3'h3;
  localparam logic [2:0] REG_POL0 = 3'h4;
  localparam logic [2:0] REG_POL1 = 3'h5;
  localparam logic [2:0] REG_CFG0 = 3'h6;
  localparam logic [2:0] REG_CFG1 = 3'h7;

  // Register pairs, selected by pointer bits 2:1
  localparam logic [1:0] PAIR_IN = REG_IN0[2:1];
  localparam logic [1:0] PAIR_OUT = REG_OUT0[2:1];
  localparam logic [1:0] PAIR_POL = REG_POL0[2:1];
  localparam logic [1:0] PAIR_CFG = REG_CFG0[2:1];

  // ************************************************************
  // Reset values, bank 1 in the upper byte
  // ************************************************************
  localparam logic [15:0] OUT_RST = 16'hFFFF;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hFFFF;

  // Fixed upper part of the 7-bit target address
  localparam logic [3:0] ADDR_HI = 4'h4;

  // ************************************************************
  // Serial framing and line filter timing
  // ************************************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] RD_LAST = 4'h7;
  localparam int FILT_NS = 50;
  localparam int LINK_PERIOD_NS = 6;
  localparam int FILT_CYC = (FILT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

  // Link-side bus state machine
  typedef enum {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_RD, ST_RD_ACK, ST_IGNORE} link_st_t;

  // Operation handed from the link domain to the register domain
  typedef enum logic [1:0] {OP_CMD, OP_WR, OP_RD} op_t;

endpackage

// *** rtl/line_if.sv ***
// Raw and filtered serial bus lines shared between core and filter
`timescale 1ns/1ps
interface line_if;
  logic scl_pin; // Raw clock line level
  logic sda_pin; // Raw data line level
  logic scl_f; // Filtered clock line
  logic sda_f; // Filtered data line
  modport filt (input scl_pin, input sda_pin, output scl_f, output sda_f);
  modport core (output scl_pin, output sda_pin, input scl_f, input sda_f);
endinterface

// *** rtl/line_filter.sv ***
// Synchroniser and spike filter for the two serial bus lines
`timescale 1ns/1ps
module line_filter
  import gpio_exp_pkg::*;
(
  // Link clock and reset
  input wire logic clk_link_in,
  input wire logic lrst_in,
  // Lines
  line_if.filt lines
);

  logic [1:0] s1_r; // First sync stage, index 1 clock, 0 data
  logic [1:0] s2_r; // Second sync stage
  logic [1:0] filt_r; // Filtered levels, idle high
  logic [3:0] cnt_r [2]; // Disagreement run length per line

  // ************************************************************
  // Two-stage synchroniser, no reset needed
  // ************************************************************
  always_ff @(posedge clk_link_in) begin
    s1_r <= {lines.scl_pin, lines.sda_pin};
    s2_r <= s1_r;
  end

  // ************************************************************
  // Spike filter: a new level must persist for the full window
  // ************************************************************
  // Trades a fixed 54 ns (nine link cycles) of latency for immunity to short spikes
  always_ff @(posedge clk_link_in) begin
    if (lrst_in) begin
      filt_r <= 2'h3;
      cnt_r[0] <= 4'h0;
      cnt_r[1] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (s2_r[i] == filt_r[i]) begin
          cnt_r[i] <= 4'h0; // Spike ended, restart window // see [R12]
        end else if (cnt_r[i] == FILT_LAST) begin
          filt_r[i] <= s2_r[i]; // see [R12]
          cnt_r[i] <= 4'h0;
        end else begin
          cnt_r[i] <= cnt_r[i] + 4'h1;
        end
      end
    end
  end

  assign lines.scl_f = filt_r[1];
  assign lines.sda_f = filt_r[0];

  // ************************************************************
  // Checks
  // ************************************************************
  a_filter_window: assert property ( // see [R12]
    @(posedge clk_link_in) disable iff (lrst_in)
    (filt_r[1] != $past(filt_r[1])) |-> ($past(cnt_r[1]) == FILT_LAST))
    else $error("clock line passed filter too early");

  a_filter_hold: assert property ( // see [R12]
    @(posedge clk_link_in) disable iff (lrst_in)
    (s2_r[0] == filt_r[0]) |=> (filt_r[0] == $past(filt_r[0])))
    else $error("data line changed without disagreement");

endmodule

// *** rtl/i2c_gpio_expander_16bit.sv ***
// Sixteen-line GPIO expander with a serial target interface
`timescale 1ns/1ps
// Behaviour
// [R1] Sixteen lines in two byte-wide banks
// [R2] Reset leaves all lines inputs with pull-ups
// [R3] Direction bit per line sets its direction
// [R4] Input register samples pins; outputs from output register
// [R5] Polarity bit inverts reported input value
// [R6] Pin differing from captured state raises interrupt
// [R7] Interrupt is open-drain, only pulls low
// [R8] Reset loads defaults and idles bus machine
// [R9] Three straps form low address bits
// [R10] Bank bits 0..7 map to lines 0..7
// [R11] Output lines push-pull from latched register
// [R12] Spikes on clock and data are filtered
// [R13] No spurious pin or interrupt activity at reset
// [R14] Command byte sets pointer to registers 0..7
// [R15] Address byte last bit selects read
// [R16] Direction one is input, zero drives
// [R17] Writes to input registers are ignored
// [R18] Reading bank or pin return releases interrupt
module i2c_gpio_expander_16bit
  import gpio_exp_pkg::*;
(
  // System clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Link sampling clock
  input wire logic clk_link_in,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Address straps
  input wire logic addr_sel0_in,
  input wire logic addr_sel1_in,
  input wire logic addr_sel2_in,
  // Bank 0 lines
  input wire logic [7:0] bank0_line_in,
  output logic [7:0] bank0_line_out,
  output logic [7:0] bank0_line_oe_out,
  output logic [7:0] bank0_pullup_out,
  // Bank 1 lines
  input wire logic [7:0] bank1_line_in,
  output logic [7:0] bank1_line_out,
  output logic [7:0] bank1_line_oe_out,
  output logic [7:0] bank1_pullup_out,
  // Interrupt pin
  output logic irq_n_out,
  output logic irq_oe_out
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Byte of a bank pair
  function automatic logic [7:0] pick(input logic [15:0] w, input logic b);
    return b ? w[15:8] : w[7:0];
  endfunction

  // Replace the byte of one bank
  function automatic logic [15:0] put(input logic [15:0] w, input logic b,
                                      input logic [7:0] v);
    return b ? {v, w[7:0]} : {w[15:8], v};
  endfunction

  // ************************************************************
  // Link domain declarations
  // ************************************************************
  logic lrst_s1_r; // Reset sync, first stage
  logic lrst_r; // Link-domain reset
  logic [2:0] strap_s1_r; // Strap sync, first stage
  logic [2:0] strap_s2_r; // Strap sync, second stage
  logic [2:0] strap_r; // Straps held from reset
  logic scl_d_r; // Filtered clock, one cycle late
  logic sda_d_r; // Filtered data, one cycle late
  link_st_t st_r; // Bus state
  logic [3:0] cnt_r; // Bit counter
  logic [7:0] sh_r; // Receive shift register
  logic [7:0] tx_r; // Transmit shift register
  logic rw_r; // Read requested by address byte
  logic cmd_seen_r; // Command byte already taken
  logic sda_oe_r; // Pulling data line low
  logic req_tgl_r; // Request toggle towards system side
  op_t req_op_r; // Requested operation
  logic [7:0] req_byte_r; // Byte carried with the request
  logic ack_s1_r; // Answer toggle sync, first stage
  logic ack_s2_r; // Answer toggle sync, second stage
  logic scl_rise, scl_fall, start, stop, busy;
  logic addr_hit, rx_done, rd_more, issue, tx_load;
  op_t issue_op;

  // ************************************************************
  // System domain declarations
  // ************************************************************
  logic req_s1_r, req_s2_r, req_s3_r; // Request toggle sync
  logic [15:0] gin_s1_r; // Pin sync, first stage
  logic [15:0] gin_s2_r; // Pin sync, second stage
  logic [15:0] out_r; // Output registers
  logic [15:0] pol_r; // Polarity inversion registers
  logic [15:0] cfg_r; // Direction registers, one is input
  logic [15:0] snap_r; // Pin state last captured by a read
  logic [2:0] ptr_r; // Register pointer
  logic base_ok_r; // Snapshot loaded after reset
  logic [7:0] rd_byte_r; // Answer byte for reads
  logic ack_tgl_r; // Answer toggle towards link side
  logic irq_r; // Interrupt pulling
  logic ev, ev_cmd, ev_wr, ev_rd;
  logic [7:0] rd_mux;

  line_if lines();
  assign lines.scl_pin = scl_in;
  assign lines.sda_pin = sda_in;

  // Synchroniser and spike filter for both bus lines
  line_filter u_filter (
    .clk_link_in(clk_link_in),
    .lrst_in(lrst_r),
    .lines(lines)
  );

  // ************************************************************
  // Link reset and strap capture
  // ************************************************************
  // Reset crosses as a level; straps are caught only while in reset
  always_ff @(posedge clk_link_in) begin
    lrst_s1_r <= srst_in;
    lrst_r <= lrst_s1_r;
    strap_s1_r <= {addr_sel2_in, addr_sel1_in, addr_sel0_in};
    strap_s2_r <= strap_s1_r;
    if (lrst_r) begin
      strap_r <= strap_s2_r; // see [R9]
    end
  end

  // Edge history of filtered lines
  always_ff @(posedge clk_link_in) begin
    if (lrst_r) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= lines.scl_f;
      sda_d_r <= lines.sda_f;
    end
  end

  // ************************************************************
  // Bus events and decodes
  // ************************************************************
  always_comb begin
    scl_rise = lines.scl_f & ~scl_d_r;
    scl_fall = ~lines.scl_f & scl_d_r;
    start = lines.scl_f & scl_d_r & sda_d_r & ~lines.sda_f;
    stop = lines.scl_f & scl_d_r & ~sda_d_r & lines.sda_f;
    busy = req_tgl_r ^ ack_s2_r;
    addr_hit = (st_r == ST_ADDR) && scl_fall && (cnt_r == BYTE_BITS)
               && (sh_r[7:1] == {ADDR_HI, strap_r}); // see [R9]
    rx_done = (st_r == ST_RX) && scl_fall && (cnt_r == BYTE_BITS);
    rd_more = (st_r == ST_RD_ACK) && scl_rise && !lines.sda_f;
    issue = (addr_hit && sh_r[0]) || rx_done || rd_more; // see [R15]
    issue_op = rx_done ? (cmd_seen_r ? OP_WR : OP_CMD) : OP_RD; // see [R14]
    tx_load = scl_fall && (((st_r == ST_ACK) && rw_r) || (st_r == ST_RD_ACK));
  end

  // ************************************************************
  // Bus state machine
  // ************************************************************
  // No clock stretching: the system side answers in a few cycles,
  // far inside one low phase of the bus clock
  always_ff @(posedge clk_link_in) begin
    if (lrst_r) begin
      st_r <= ST_IDLE; // see [R8]
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      cmd_seen_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start) begin
      st_r <= ST_ADDR;
      cnt_r <= 4'h0;
      cmd_seen_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (stop) begin
      st_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        ST_ADDR, ST_RX: begin
          if (scl_rise && (cnt_r != BYTE_BITS)) begin
            sh_r <= {sh_r[6:0], lines.sda_f};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && (cnt_r == BYTE_BITS)) begin
            if (st_r == ST_RX) begin
              sda_oe_r <= 1'b1; // Data and command bytes always acked
              cmd_seen_r <= 1'b1;
              st_r <= ST_ACK;
            end else if (addr_hit) begin
              sda_oe_r <= 1'b1; // see [R9]
              rw_r <= sh_r[0]; // see [R15]
              st_r <= ST_ACK;
            end else begin
              st_r <= ST_IGNORE; // Another target on the bus
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              tx_r <= rd_byte_r; // see [R15]
              sda_oe_r <= ~rd_byte_r[7];
              st_r <= ST_RD;
            end else begin
              sda_oe_r <= 1'b0;
              st_r <= ST_RX;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_r == RD_LAST) begin
              sda_oe_r <= 1'b0; // Release for master acknowledge
              st_r <= ST_RD_ACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && lines.sda_f) begin
            st_r <= ST_IGNORE; // Not acknowledged: read ends
          end else if (scl_fall) begin
            tx_r <= rd_byte_r;
            sda_oe_r <= ~rd_byte_r[7];
            cnt_r <= 4'h0;
            st_r <= ST_RD;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Request handshake, link side
  // ************************************************************
  // Op and byte stay stable until the answer toggle returns
  always_ff @(posedge clk_link_in) begin
    if (lrst_r) begin
      req_tgl_r <= 1'b0;
      req_op_r <= OP_CMD;
      req_byte_r <= 8'h00;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      if (issue && !busy) begin
        req_tgl_r <= ~req_tgl_r; // see [R14]
        req_op_r <= issue_op;
        req_byte_r <= sh_r;
      end
    end
  end

  // ************************************************************
  // Request handshake, system side
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  // Pins pass two flip-flops before any logic reads them
  always_ff @(posedge clk_sys_in) begin
    gin_s1_r <= {bank1_line_in, bank0_line_in}; // see [R10]
    gin_s2_r <= gin_s1_r;
  end

  always_comb begin
    ev = req_s2_r ^ req_s3_r;
    ev_cmd = ev && (req_op_r == OP_CMD);
    ev_wr = ev && (req_op_r == OP_WR);
    ev_rd = ev && (req_op_r == OP_RD);
    case (ptr_r[2:1])
      PAIR_IN: rd_mux = pick(gin_s2_r ^ pol_r, ptr_r[0]); // see [R4] [R5]
      PAIR_OUT: rd_mux = pick(out_r, ptr_r[0]);
      PAIR_POL: rd_mux = pick(pol_r, ptr_r[0]);
      default: rd_mux = pick(cfg_r, ptr_r[0]);
    endcase
  end

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      out_r <= OUT_RST; // see [R8]
      pol_r <= POL_RST;
      cfg_r <= CFG_RST; // see [R2]
    end else if (ev_wr) begin
      case (ptr_r[2:1])
        PAIR_OUT: out_r <= put(out_r, ptr_r[0], req_byte_r); // see [R11]
        PAIR_POL: pol_r <= put(pol_r, ptr_r[0], req_byte_r);
        PAIR_CFG: cfg_r <= put(cfg_r, ptr_r[0], req_byte_r); // see [R3]
        default: ; // Input pair is read-only // see [R17]
      endcase
    end
  end

  // Pointer: command loads it, data bytes walk within the pair
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ptr_r <= REG_IN0;
    end else if (ev_cmd) begin
      ptr_r <= req_byte_r[2:0]; // see [R14]
    end else if (ev_wr || ev_rd) begin
      ptr_r <= {ptr_r[2:1], ~ptr_r[0]};
    end
  end

  // Answer every request; reads also return a byte
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rd_byte_r <= 8'h00;
      ack_tgl_r <= 1'b0;
    end else if (ev) begin
      ack_tgl_r <= ~ack_tgl_r;
      if (ev_rd) begin
        rd_byte_r <= rd_mux;
      end
    end
  end

  // ************************************************************
  // Change detection and interrupt
  // ************************************************************
  // Snapshot is loaded once after reset so power-up never interrupts
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      snap_r <= 16'h0000;
      base_ok_r <= 1'b0;
      irq_r <= 1'b0; // see [R13]
    end else begin
      if (!base_ok_r) begin
        snap_r <= gin_s2_r;
        base_ok_r <= 1'b1;
      end else if (ev_rd && (ptr_r[2:1] == PAIR_IN)) begin
        snap_r <= put(snap_r, ptr_r[0], pick(gin_s2_r, ptr_r[0])); // see [R18]
      end
      // Mismatch is re-evaluated every cycle; a change sampled with a read goes into the snapshot and pulls the interrupt one cycle only
      irq_r <= base_ok_r && (gin_s2_r != snap_r); // see [R6] [R18]
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign sda_out = 1'b0; // Open drain: only pulls low
  assign sda_oe_out = sda_oe_r;
  assign bank0_line_out = out_r[7:0]; // see [R10] [R11]
  assign bank1_line_out = out_r[15:8];
  assign bank0_line_oe_out = ~cfg_r[7:0]; // see [R16] [R1]
  assign bank1_line_oe_out = ~cfg_r[15:8];
  assign bank0_pullup_out = cfg_r[7:0]; // see [R2]
  assign bank1_pullup_out = cfg_r[15:8];
  assign irq_n_out = 1'b0; // see [R7]
  assign irq_oe_out = irq_r;

  // ************************************************************
  // Checks
  // ************************************************************
  a_reset_quiet: assert property ( // see [R13]
    @(posedge clk_sys_in) disable iff (srst_in)
    $fell(srst_in) |-> (!irq_oe_out && (bank0_line_oe_out == 8'h00)
                        && (bank1_pullup_out == 8'hFF) && (ptr_r == REG_IN0)))
    else $error("outputs not quiet after reset");

  a_cmd_ptr: assert property ( // see [R14]
    @(posedge clk_sys_in) disable iff (srst_in)
    ev_cmd |=> (ptr_r == $past(req_byte_r[2:0])))
    else $error("command byte not loaded into pointer");

  a_out_bank0: assert property ( // see [R4]
    @(posedge clk_sys_in) disable iff (srst_in)
    (ev_wr && (ptr_r == REG_OUT0)) |=> (bank0_line_out == $past(req_byte_r)))
    else $error("bank 0 output not taken from write");

  a_dir_bank1: assert property ( // see [R3]
    @(posedge clk_sys_in) disable iff (srst_in)
    (ev_wr && (ptr_r == REG_CFG1)) |=> (bank1_line_oe_out == ~$past(req_byte_r)))
    else $error("bank 1 direction not taken from write");

  a_in_readonly: assert property ( // see [R17]
    @(posedge clk_sys_in) disable iff (srst_in)
    (ev_wr && (ptr_r[2:1] == PAIR_IN)) |=> ($stable(out_r) && $stable(pol_r)
                                            && $stable(cfg_r)))
    else $error("write to input register changed state");

  a_pol_read: assert property ( // see [R5]
    @(posedge clk_sys_in) disable iff (srst_in)
    (ev_rd && (ptr_r == REG_IN1)) |=>
      (rd_byte_r == $past(gin_s2_r[15:8] ^ pol_r[15:8])))
    else $error("input read ignores polarity");

  a_irq_raise: assert property ( // see [R6]
    @(posedge clk_sys_in) disable iff (srst_in)
    (base_ok_r && (gin_s2_r != snap_r)) |=> (irq_oe_out && (irq_n_out == 1'b0)))
    else $error("pin change did not pull interrupt low");

  a_irq_release: assert property ( // see [R18]
    @(posedge clk_sys_in) disable iff (srst_in)
    (gin_s2_r == snap_r) [*2] |=> !irq_oe_out)
    else $error("interrupt held without a change");

  a_addr_ack: assert property ( // see [R9]
    @(posedge clk_link_in) disable iff (lrst_r)
    addr_hit |=> (sda_oe_out && (st_r == ST_ACK)))
    else $error("matching address not acknowledged");

  a_rw_read: assert property ( // see [R15]
    @(posedge clk_link_in) disable iff (lrst_r)
    ((st_r == ST_ACK) && scl_fall && rw_r) |=> (st_r == ST_RD))
    else $error("read bit did not start a read");

  a_load_ready: assert property ( // see [R15]
    @(posedge clk_link_in) disable iff (lrst_r)
    tx_load |-> !busy)
    else $error("read byte loaded before answer returned");

  c_cfg_write: cover property (@(posedge clk_sys_in) ev_wr && (ptr_r[2:1] == PAIR_CFG));
  c_in_read: cover property (@(posedge clk_sys_in) ev_rd && (ptr_r[2:1] == PAIR_IN));
  c_irq_cycle: cover property (@(posedge clk_sys_in) $rose(irq_r) ##[1:1000] $fell(irq_r));
  c_read_nack: cover property (@(posedge clk_link_in)
    (st_r == ST_RD_ACK) && scl_rise && lines.sda_f);

endmodule

// *** tb/bus_master.sv ***
// Serial bus master model that faces the expander's target port
`timescale 1ns/1ps
module bus_master (
  // Pacing clock
  input wire logic clk_in,
  // Device side of the bus
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic sda_drv; // Master data drive, high means released
  // Pull-up wins unless a party pulls low
  assign sda_out = sda_drv & ~sda_oe_in;
  initial begin
    scl_out = 1'b1;
    sda_drv = 1'b1;
  end
  // One quarter bit, slow enough to pass the spike filter
  task automatic drv(input logic c, input logic d);
    scl_out = c;
    sda_drv = d;
    repeat (20) @(negedge clk_in);
  endtask
  // Start or repeated start, clock left low
  task automatic start();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask
  // Stop, bus left idle high
  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask
  // Data changes only while the clock is low
  task automatic bitx(input logic b, output logic r);
    drv(1'b0, b);
    drv(1'b1, b);
    r = sda_out;
    drv(1'b1, b);
    drv(1'b0, b);
  endtask
  // Byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ack_in, ack_out);
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the sixteen-line serial expander
`timescale 1ns/1ps
module testbench;
  import gpio_exp_pkg::*;
  logic clk_sys = 1'b0; // System clock
  logic clk_link = 1'b0; // Link clock, own phase
  logic srst = 1'b1; // Reset
  logic [7:0] b0_in = 8'h00; // Bank 0 pins
  logic [7:0] b1_in = 8'h00; // Bank 1 pins
  logic scl, sda, sda_o, sda_oe, irq_n, irq_oe;
  logic [7:0] b0_out, b0_oe, b0_pu, b1_out, b1_oe, b1_pu;
  logic [7:0] exp_r [8]; // Expected register contents
  logic [7:0] d0, d1, r;
  logic a;
  int err_total = 0;
  int checked = 0;
  localparam logic [2:0] STRAP = 3'h5; // Straps held fixed
  logic [2:0] row_p [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [7:0] row_d [6] = '{8'hA5, 8'h3C, 8'h0F, 8'hF0, 8'h00, 8'h81};
  always #5 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #3 clk_link = ~clk_link;
  end
  i2c_gpio_expander_16bit i2c_gpio_expander_16bit_i (.clk_sys_in(clk_sys), .srst_in(srst),
    .clk_link_in(clk_link), .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .addr_sel0_in(STRAP[0]), .addr_sel1_in(STRAP[1]), .addr_sel2_in(STRAP[2]),
    .bank0_line_in(b0_in), .bank0_line_out(b0_out), .bank0_line_oe_out(b0_oe),
    .bank0_pullup_out(b0_pu), .bank1_line_in(b1_in), .bank1_line_out(b1_out),
    .bank1_line_oe_out(b1_oe), .bank1_pullup_out(b1_pu), .irq_n_out(irq_n),
    .irq_oe_out(irq_oe));
  bus_master bus_master_i (.clk_in(clk_sys), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  // ***************************
  // Shared tasks
  // ***************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic settle();
    repeat (10) @(negedge clk_sys);
  endtask
  // Address for write, then pointer byte
  task automatic hdr(input logic [2:0] p);
    bus_master_i.start();
    bus_master_i.xfer({ADDR_HI, STRAP, 1'b0}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    bus_master_i.xfer({5'h00, p}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
  endtask
  task automatic wr(input logic [2:0] p, input logic [7:0] d);
    hdr(p);
    bus_master_i.xfer(d, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    bus_master_i.stop();
  endtask
  // Two bytes read back, the second from the paired register
  task automatic rd(input logic [2:0] p);
    hdr(p);
    bus_master_i.start();
    bus_master_i.xfer({ADDR_HI, STRAP, 1'b1}, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    bus_master_i.xfer(8'hFF, 1'b0, d0, a);
    bus_master_i.xfer(8'hFF, 1'b1, d1, a);
    bus_master_i.stop();
  endtask
  // Pins must follow the output and direction registers
  task automatic ports();
    chk(b0_out, exp_r[2]);
    chk(b1_out, exp_r[3]);
    chk(b0_oe, ~exp_r[6]);
    chk(b1_oe, ~exp_r[7]);
    chk(b0_pu, exp_r[6]);
    chk(b1_pu, exp_r[7]);
  endtask
  task automatic do_reset();
    srst = 1'b1;
    repeat (8) @(negedge clk_sys);
    srst = 1'b0;
    exp_r = '{8'h00, 8'h00, OUT_RST[7:0], OUT_RST[15:8], POL_RST[7:0], POL_RST[15:8],
              CFG_RST[7:0], CFG_RST[15:8]};
    @(posedge clk_sys);
    #1;
    ports();
    chk({5'h00, sda_o, irq_oe, sda_oe}, 8'h00);
    repeat (20) @(negedge clk_sys);
  endtask
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ***************************
  // Main sequence and watchdog
  // ***************************
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    test_done();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 6; i++) begin
      wr(row_p[i], row_d[i]);
      exp_r[row_p[i]] = row_d[i];
      settle();
      ports();
      rd(row_p[i]);
      chk(d0, exp_r[row_p[i]]);
      chk(d1, exp_r[row_p[i] ^ 3'h1]);
    end
    // Two data bytes in one write walk the pointer within the pair
    hdr(REG_OUT0);
    bus_master_i.xfer(8'h12, 1'b1, r, a);
    bus_master_i.xfer(8'h34, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    bus_master_i.stop();
    exp_r[2] = 8'h12;
    exp_r[3] = 8'h34;
    settle();
    ports();
    b0_in = 8'h55;
    b1_in = 8'h33;
    settle();
    chk({irq_n, 6'h00, irq_oe}, 8'h01);
    wr(REG_IN0, 8'hFF);
    rd(REG_IN0);
    chk(d0, 8'h55 ^ exp_r[4]);
    chk(d1, 8'h33 ^ exp_r[5]);
    settle();
    chk({7'h00, irq_oe}, 8'h00);
    b1_in = 8'h32;
    settle();
    chk({7'h00, irq_oe}, 8'h01);
    b1_in = 8'h33;
    settle();
    chk({7'h00, irq_oe}, 8'h00);
    bus_master_i.start();
    bus_master_i.xfer({ADDR_HI, ~STRAP, 1'b0}, 1'b1, r, a);
    chk({7'h00, a}, 8'h01);
    bus_master_i.stop();
    do_reset();
    test_done();
  end
endmodule
